// ===== logic/scs_pkg.sv
// Purpose: Shared constants and types for the system clock selector
// Assumes: REF_CLK at 100 MHz; registers reached over APB with 32-bit data
// Notes:   Oscillator rates are modelled as enable pulses derived from REF_CLK
package scs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] FAIL_STAT_OFFSET = 12'h004;
  localparam int FREQ_LSB = 4;
  localparam int FREQ_MSB = 6;
  localparam int EXTERNAL_CLOCK_RUNNING_STATUS_BIT = 3;
  localparam int HTS_BIT = 2;
  localparam int LTS_BIT = 1;
  localparam int SCS_BIT = 0;
  localparam int FAIL_BIT = 0;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic SCS_RESET = 1'h0;
  localparam logic [2:0] FREQ_SLOW = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int REF_PERIOD_PS = 10000;
  localparam int FAST_OSC_PERIOD_PS = 125000;
  localparam int SLOW_OSC_PERIOD_PS = 32258064;
  localparam int FAST_DIV_CYCLES = FAST_OSC_PERIOD_PS / REF_PERIOD_PS;
  localparam int SLOW_DIV_CYCLES = SLOW_OSC_PERIOD_PS / REF_PERIOD_PS;
  localparam logic [10:0] OST_CYCLES = 11'h400;
  localparam logic [3:0] WARM_TICKS = 4'h8;
  localparam logic [1:0] FAIL_SLOW_TICKS = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    MODE_LOW_POWER_XTAL = 3'b000,
    MODE_MEDIUM_GAIN = 3'b001,
    MODE_HIGH_GAIN = 3'b010,
    MODE_EXT_CLOCK = 3'b011,
    MODE_INT_PIN_IO = 3'b100,
    MODE_INT_CLOCKOUT = 3'b101,
    MODE_RC_IO = 3'b110,
    MODE_RC = 3'b111
  } scs_mode_t;

  typedef enum logic [1:0] {
    SW_INT = 2'b00,
    SW_TO_EXT = 2'b01,
    SW_EXT = 2'b10,
    SW_TO_INT = 2'b11
  } scs_sw_t;

  function automatic logic scs_is_xtal(input scs_mode_t mode);
    scs_is_xtal = (mode == MODE_LOW_POWER_XTAL) || (mode == MODE_MEDIUM_GAIN) ||
                  (mode == MODE_HIGH_GAIN);
  endfunction : scs_is_xtal

  function automatic logic scs_is_ext(input scs_mode_t mode);
    scs_is_ext = scs_is_xtal(mode) || (mode == MODE_EXT_CLOCK) ||
                 (mode == MODE_RC) || (mode == MODE_RC_IO);
  endfunction : scs_is_ext

endpackage : scs_pkg

// ===== logic/scs_clock_selector.sv
// Purpose: System clock source selection, start-up timing and failure fallback
// Assumes: CFG_* are static config-word levels; the oscillator pins are async
// Notes:   The system clock leaves as a one-cycle enable, SYS_CLK_EN
//
// Function
// R1: Eight clock source modes, one active
// R2: Mode comes from three-bit config word field
// R3: External clock mode: input clock, output pin GPIO
// R4: Low power mode for 32 kHz crystal
// R5: Medium and high gain resonator modes
// R6: RC mode drives output pin with Fosc/4
// R7: RC I/O mode frees output pin as GPIO
// R8: Internal clockout mode: Fosc/4 out, input GPIO
// R9: Internal pin I/O mode frees both pins
// R10: Monitor detects lost external clock, falls back
// R11: Control bit 7 ignores writes, reads zero
// R12: Frequency field picks 8 MHz down to 31 kHz
// R13: Frequency field resets to 4 MHz code
// R14: Status bit 3 shows external clock running
// R15: Bit 2 shows fast oscillator stable
// R16: Bit 1 shows slow oscillator stable
// R17: Bit 0 forces internal clock, resets zero
// R18: Status bit 3 reset value depends on config
// R19: Crystal modes wait 1024 cycles, execution held
// R20: External clock mode has no start-up wait
// R21: Fast 8 MHz and slow 31 kHz oscillators
// R22: Fallback sets fail flag until software clears
// R23: Switching never shortens a system clock pulse
`timescale 1ns/1ps
module scs_clock_selector
  import scs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] CFG_MODE,
  input wire logic CFG_TWO_SPEED,
  input wire logic CFG_MONITOR_EN,
  input wire logic WAKE,
  input wire logic OSC_IN_PIN_I,
  output logic OSC_IN_PIN_O,
  output logic OSC_IN_PIN_OE_N,
  input wire logic OSC_OUT_PIN_I,
  output logic OSC_OUT_PIN_O,
  output logic OSC_OUT_PIN_OE_N,
  input wire logic [1:0] GPIO_DOUT,
  input wire logic [1:0] GPIO_DRIVE,
  output logic [1:0] GPIO_DIN,
  output logic SYS_CLK_EN,
  output logic EXT_CLK_ACTIVE,
  output logic HOLD_EXEC
);

  localparam logic [3:0] FAST_LAST = 4'(FAST_DIV_CYCLES - 1);
  localparam logic [11:0] SLOW_LAST = 12'(SLOW_DIV_CYCLES - 1);

  // Internal rate hit: code 7 passes every fast tick, each lower code down to 1 halves it
  function automatic logic div_hit(input logic [5:0] pre, input logic [2:0] code);
    logic [5:0] mask;
    mask = 6'h3f >> (code - 3'h1);
    div_hit = ((pre & mask) == mask);
  endfunction : div_hit

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture
  scs_mode_t cfg_mode;
  logic cfg_two_speed;
  logic cfg_monitor_en;
  logic cfg_loaded;
  scs_mode_t next_cfg_mode;
  logic next_cfg_two_speed;
  logic next_cfg_monitor_en;
  logic next_cfg_loaded;

  always_comb
  begin
    next_cfg_mode = cfg_mode;
    next_cfg_two_speed = cfg_two_speed;
    next_cfg_monitor_en = cfg_monitor_en;
    next_cfg_loaded = 1'h1;
    if (!cfg_loaded)
    begin
      next_cfg_mode = scs_mode_t'(CFG_MODE); // see R2
      next_cfg_two_speed = CFG_TWO_SPEED;
      next_cfg_monitor_en = CFG_MONITOR_EN;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cfg_mode <= MODE_EXT_CLOCK;
      cfg_two_speed <= 1'h0;
      cfg_monitor_en <= 1'h0;
      cfg_loaded <= 1'h0;
    end
    else
    begin
      cfg_mode <= next_cfg_mode;
      cfg_two_speed <= next_cfg_two_speed;
      cfg_monitor_en <= next_cfg_monitor_en;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillators and frequency divider
  logic [3:0] fast_cnt;
  logic [11:0] slow_cnt;
  logic [3:0] fast_warm;
  logic [3:0] slow_warm;
  logic [5:0] prescale;
  logic [3:0] next_fast_cnt;
  logic [11:0] next_slow_cnt;
  logic [3:0] next_fast_warm;
  logic [3:0] next_slow_warm;
  logic [5:0] next_prescale;
  logic fast_tick;
  logic slow_tick;
  logic fast_stable;
  logic slow_stable;
  logic int_tick;
  logic [2:0] freq_sel;

  always_comb
  begin
    fast_tick = (fast_cnt == FAST_LAST); // see R21
    slow_tick = (slow_cnt == SLOW_LAST); // see R21
    fast_stable = (fast_warm == WARM_TICKS);
    slow_stable = (slow_warm == WARM_TICKS);
    next_fast_cnt = fast_tick ? 4'h0 : fast_cnt + 4'h1;
    next_slow_cnt = slow_tick ? 12'h000 : slow_cnt + 12'h001;
    next_fast_warm = (fast_tick && !fast_stable) ? fast_warm + 4'h1 : fast_warm;
    next_slow_warm = (slow_tick && !slow_stable) ? slow_warm + 4'h1 : slow_warm;
    next_prescale = fast_tick ? prescale + 6'h01 : prescale;
    // Frequency changes apply at once, but int_tick fires only on a tick, so no pulse is cut short
    if (freq_sel == FREQ_SLOW)
      int_tick = slow_tick; // see R12
    else
      int_tick = fast_tick && div_hit(prescale, freq_sel); // see R12, R23
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      fast_cnt <= 4'h0;
      slow_cnt <= 12'h000;
      fast_warm <= 4'h0;
      slow_warm <= 4'h0;
      prescale <= 6'h00;
    end
    else
    begin
      fast_cnt <= next_fast_cnt;
      slow_cnt <= next_slow_cnt;
      fast_warm <= next_fast_warm;
      slow_warm <= next_slow_warm;
      prescale <= next_prescale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock sensing, start-up count and failure monitor
  logic in_s1;
  logic in_s2;
  logic in_s3;
  logic out_s1;
  logic out_s2;
  logic [10:0] ost_cnt;
  logic [1:0] fail_cnt;
  logic failed;
  logic [10:0] next_ost_cnt;
  logic [1:0] next_fail_cnt;
  logic next_failed;
  logic ext_edge;
  logic ost_done;
  logic ext_ready;
  logic monitor_on;
  logic fail_detect;
  logic fail_clear;

  always_comb
  begin
    ext_edge = in_s2 && !in_s3;
    ost_done = (ost_cnt == OST_CYCLES);
    // No start-up wait in the clock input and RC modes
    ext_ready = scs_is_xtal(cfg_mode) ? ost_done : 1'h1; // see R19, R20
    next_ost_cnt = ost_cnt;
    if (!cfg_loaded || WAKE)
      next_ost_cnt = 11'h000; // see R19
    else if (scs_is_xtal(cfg_mode) && ext_edge && !ost_done)
      next_ost_cnt = ost_cnt + 11'h001; // see R19
    // Crystals are watched only after the start-up count; clock input and RC sources are watched at once
    monitor_on = cfg_loaded && cfg_monitor_en && scs_is_ext(cfg_mode) && ext_ready;
    fail_detect = monitor_on && !failed && slow_tick && !ext_edge &&
                  (fail_cnt == FAIL_SLOW_TICKS - 2'h1); // see R10
    next_fail_cnt = fail_cnt;
    if (ext_edge || !monitor_on || failed)
      next_fail_cnt = 2'h0;
    else if (slow_tick)
      next_fail_cnt = fail_cnt + 2'h1;
    next_failed = failed;
    if (fail_detect)
      next_failed = 1'h1; // see R10
    else if (fail_clear)
      next_failed = 1'h0;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      in_s1 <= 1'h0;
      in_s2 <= 1'h0;
      in_s3 <= 1'h0;
      out_s1 <= 1'h0;
      out_s2 <= 1'h0;
      ost_cnt <= 11'h000;
      fail_cnt <= 2'h0;
      failed <= 1'h0;
    end
    else
    begin
      in_s1 <= OSC_IN_PIN_I;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      out_s1 <= OSC_OUT_PIN_I;
      out_s2 <= out_s1;
      ost_cnt <= next_ost_cnt;
      fail_cnt <= next_fail_cnt;
      failed <= next_failed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source switch, system clock, clock out
  scs_sw_t sw_state;
  scs_sw_t next_sw_state;
  logic scs;
  logic want_ext;
  logic next_sys_clk_en;
  logic next_ext_clk_active;
  logic next_hold_exec;
  logic clk_phase;
  logic divided_clock_output;
  logic next_clk_phase;
  logic next_divided_clock_output;

  always_comb
  begin
    want_ext = cfg_loaded && scs_is_ext(cfg_mode) && !scs && !failed && ext_ready; // see R17
    next_sw_state = sw_state;
    next_sys_clk_en = 1'h0;
    case (sw_state)
      SW_INT:
      begin
        next_sys_clk_en = int_tick;
        if (want_ext)
          next_sw_state = SW_TO_EXT;
      end
      SW_TO_EXT:
      begin
        // Old source keeps running until the new one starts a full pulse
        next_sys_clk_en = int_tick || ext_edge; // see R23
        if (!want_ext)
          next_sw_state = SW_INT;
        else if (ext_edge)
          next_sw_state = SW_EXT;
      end
      SW_EXT:
      begin
        next_sys_clk_en = ext_edge; // see R3
        if (failed)
          next_sw_state = SW_INT; // see R10
        else if (!want_ext)
          next_sw_state = SW_TO_INT;
      end
      SW_TO_INT:
      begin
        next_sys_clk_en = int_tick; // see R23
        if (int_tick)
          next_sw_state = SW_INT;
      end
      default:
        next_sw_state = SW_INT;
    endcase
    next_ext_clk_active = (next_sw_state == SW_EXT) && !failed; // see R14
    // Held only while a crystal warms up with no internal clock to run on
    next_hold_exec = cfg_loaded && scs_is_xtal(cfg_mode) && !ost_done && !failed &&
                     !cfg_two_speed && !scs; // see R19, R20
    next_clk_phase = clk_phase;
    next_divided_clock_output = divided_clock_output;
    if (SYS_CLK_EN)
    begin
      next_clk_phase = !clk_phase;
      if (clk_phase)
        next_divided_clock_output = !divided_clock_output; // see R6, R8
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sw_state <= SW_INT;
      SYS_CLK_EN <= 1'h0;
      EXT_CLK_ACTIVE <= 1'h0;
      HOLD_EXEC <= 1'h0;
      clk_phase <= 1'h0;
      divided_clock_output <= 1'h0;
    end
    else
    begin
      sw_state <= next_sw_state;
      SYS_CLK_EN <= next_sys_clk_en;
      EXT_CLK_ACTIVE <= next_ext_clk_active;
      HOLD_EXEC <= next_hold_exec;
      clk_phase <= next_clk_phase;
      divided_clock_output <= next_divided_clock_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership per mode
  logic next_in_o;
  logic next_in_oe_n;
  logic next_out_o;
  logic next_out_oe_n;

  always_comb
  begin
    next_in_o = 1'h0;
    next_in_oe_n = 1'h1;
    next_out_o = 1'h0;
    next_out_oe_n = 1'h1;
    // Crystal pins stay undriven: the amplifier sits outside this logic
    if (cfg_loaded)
    begin
      case (cfg_mode) // see R1, R4, R5
        MODE_EXT_CLOCK, MODE_RC_IO:
        begin
          next_out_o = GPIO_DOUT[1]; // see R3, R7
          next_out_oe_n = !GPIO_DRIVE[1];
        end
        MODE_RC:
        begin
          next_out_o = divided_clock_output; // see R6
          next_out_oe_n = 1'h0;
        end
        MODE_INT_CLOCKOUT:
        begin
          next_in_o = GPIO_DOUT[0]; // see R8
          next_in_oe_n = !GPIO_DRIVE[0];
          next_out_o = divided_clock_output;
          next_out_oe_n = 1'h0;
        end
        MODE_INT_PIN_IO:
        begin
          next_in_o = GPIO_DOUT[0]; // see R9
          next_in_oe_n = !GPIO_DRIVE[0];
          next_out_o = GPIO_DOUT[1];
          next_out_oe_n = !GPIO_DRIVE[1];
        end
        default:
        begin
          next_in_oe_n = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      OSC_IN_PIN_O <= 1'h0;
      OSC_IN_PIN_OE_N <= 1'h1;
      OSC_OUT_PIN_O <= 1'h0;
      OSC_OUT_PIN_OE_N <= 1'h1;
    end
    else
    begin
      OSC_IN_PIN_O <= next_in_o;
      OSC_IN_PIN_OE_N <= next_in_oe_n;
      OSC_OUT_PIN_O <= next_out_o;
      OSC_OUT_PIN_OE_N <= next_out_oe_n;
    end
  end

  assign GPIO_DIN = {out_s2, in_s2};

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic fail_flag;
  logic [2:0] next_freq_sel;
  logic next_scs;
  logic next_fail_flag;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic external_clock_running_status;
  logic wr_en;
  logic ctrl_hit;
  logic fail_hit;

  always_comb
  begin
    ctrl_hit = (PADDR == OSC_CTRL_OFFSET);
    fail_hit = (PADDR == FAIL_STAT_OFFSET);
    wr_en = PSEL && PENABLE && PREADY && PWRITE;
    // Reads 1 through a plain crystal start-up with the monitor off; 0 with the monitor on or when the wait runs internally
    external_clock_running_status = EXT_CLK_ACTIVE || (HOLD_EXEC && !cfg_monitor_en); // see R14, R18
    next_pready = PSEL && PENABLE && !PREADY;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'h0;
    if (next_pready && !PWRITE)
    begin
      if (ctrl_hit)
      begin
        next_prdata[FREQ_MSB:FREQ_LSB] = freq_sel; // see R11
        next_prdata[EXTERNAL_CLOCK_RUNNING_STATUS_BIT] = external_clock_running_status; // see R14
        next_prdata[HTS_BIT] = fast_stable; // see R15
        next_prdata[LTS_BIT] = slow_stable; // see R16
        next_prdata[SCS_BIT] = scs;
      end
      else if (fail_hit)
        next_prdata[FAIL_BIT] = fail_flag;
    end
    if (next_pready && !ctrl_hit && !fail_hit)
      next_pslverr = 1'h1;
    next_freq_sel = freq_sel;
    next_scs = scs;
    fail_clear = wr_en && fail_hit && PWDATA[FAIL_BIT];
    if (wr_en && ctrl_hit)
    begin
      next_freq_sel = PWDATA[FREQ_MSB:FREQ_LSB]; // see R12
      next_scs = PWDATA[SCS_BIT]; // see R17
    end
    next_fail_flag = fail_flag;
    if (fail_detect)
      next_fail_flag = 1'h1; // see R22
    else if (fail_clear)
      next_fail_flag = 1'h0;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      freq_sel <= FREQ_RESET; // see R13
      scs <= SCS_RESET; // see R17
      fail_flag <= 1'h0;
      PREADY <= 1'h0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'h0;
    end
    else
    begin
      freq_sel <= next_freq_sel;
      scs <= next_scs;
      fail_flag <= next_fail_flag;
      PREADY <= next_pready;
      PRDATA <= next_prdata;
      PSLVERR <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_xtal_start;
    cfg_loaded && scs_is_xtal(cfg_mode) && !WAKE && ost_cnt == 11'h3ff && ext_edge;
  endsequence
  sequence s_count_done;
    ##1 ost_done;
  endsequence

  property p_bit7_zero;
    PREADY && !PSLVERR && $past(ctrl_hit) |-> PRDATA[7] == 1'h0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("Control bit 7 read non-zero"); // see R11

  property p_freq_reset;
    $rose(cfg_loaded) |-> freq_sel == 3'h6;
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("Frequency reset code wrong"); // see R13

  property p_scs_internal;
    scs |-> ##[1:2] !EXT_CLK_ACTIVE;
  endproperty
  a_scs_internal: assert property (p_scs_internal) else $error("Forced internal ignored"); // see R17

  property p_fail_fallback;
    fail_detect |=> failed && fail_flag ##1 !EXT_CLK_ACTIVE;
  endproperty
  a_fail_fallback: assert property (p_fail_fallback) else $error("No fallback on failure"); // see R10

  property p_fail_sticky;
    fail_flag && !fail_clear |=> fail_flag;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("Fail flag dropped"); // see R22

  property p_ost_done;
    s_xtal_start |-> s_count_done;
  endproperty
  a_ost_done: assert property (p_ost_done) else $error("Start-up count wrong"); // see R19

  property p_ec_no_hold;
    cfg_loaded && cfg_mode == MODE_EXT_CLOCK |=> !HOLD_EXEC;
  endproperty
  a_ec_no_hold: assert property (p_ec_no_hold) else $error("Clock input mode held"); // see R20

  property p_divided_clock_output_pin;
    cfg_loaded && (cfg_mode == MODE_RC || cfg_mode == MODE_INT_CLOCKOUT)
      |=> !OSC_OUT_PIN_OE_N && OSC_OUT_PIN_O == $past(divided_clock_output);
  endproperty
  a_divided_clock_output_pin: assert property (p_divided_clock_output_pin) else $error("Clock out not driven"); // see R6

  property p_divided_clock_output_div4;
    $changed(divided_clock_output) |-> $past(SYS_CLK_EN) && $past(clk_phase);
  endproperty
  a_divided_clock_output_div4: assert property (p_divided_clock_output_div4) else $error("Clock out not quarter rate"); // see R8

  property p_pins_free;
    cfg_loaded && cfg_mode == MODE_INT_PIN_IO && GPIO_DRIVE == 2'h0
      |=> OSC_IN_PIN_OE_N && OSC_OUT_PIN_OE_N;
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("Pin not released"); // see R9

  property p_fast_stable;
    $rose(fast_stable) |-> $past(fast_tick);
  endproperty
  a_fast_stable: assert property (p_fast_stable) else $error("Fast stable without tick"); // see R15

endmodule : scs_clock_selector

// ===== verif/scs_ext_osc.sv
// Purpose: External oscillator or clock source on the input pin
// Assumes: HALF counts REF_CLK cycles per half period, at least 2
// Notes:   A stopped source stands still, as a dead crystal would
`timescale 1ns/1ps
module scs_ext_osc
#(
  parameter int HALF = 3
)
(
  input wire logic clk,
  input wire logic run,
  output logic pin
);
  int cnt = 0;

  initial pin = 1'b0;

  always @(posedge clk)
  begin
    if (run !== 1'b1)
    begin
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      pin <= ~pin;
    end
    else
    begin
      cnt <= cnt + 1;
    end
  end
endmodule : scs_ext_osc

// ===== verif/scs_clock_selector_tb_top.sv
// Purpose: Self-checking bench for the system clock selector
// Assumes: APB answers within 50 cycles; notes are checked in order
// Notes:   Fail detection can take up to two slow ticks, so waits are long
`timescale 1ns/1ps
module scs_clock_selector_tb_top
  import scs_pkg::*;
;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] cfg_mode = 3'h3;
  logic two_speed = 0;
  logic mon_en = 1;
  logic run = 0;
  logic wake = 0;
  logic osc_in;
  logic in_o;
  logic in_oe_n;
  logic out_o;
  logic out_oe_n;
  logic [1:0] gpio_dout = 2'h3;
  logic [1:0] gpio_drive = 2'h3;
  logic [1:0] gpio_din;
  logic sys_en;
  logic ext_act;
  logic hold;
  logic [31:0] st = 32'hf;
  logic [32:0] exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  scs_ext_osc #(.HALF(3)) osc (.clk(ref_clk), .run(run), .pin(osc_in));

  scs_clock_selector dut (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CFG_MODE(cfg_mode),
    .CFG_TWO_SPEED(two_speed), .CFG_MONITOR_EN(mon_en), .WAKE(wake),
    .OSC_IN_PIN_I(in_oe_n ? osc_in : in_o), .OSC_IN_PIN_O(in_o),
    .OSC_IN_PIN_OE_N(in_oe_n), .OSC_OUT_PIN_I(out_oe_n ? 1'b1 : out_o),
    .OSC_OUT_PIN_O(out_o), .OSC_OUT_PIN_OE_N(out_oe_n),
    .GPIO_DOUT(gpio_dout), .GPIO_DRIVE(gpio_drive), .GPIO_DIN(gpio_din),
    .SYS_CLK_EN(sys_en), .EXT_CLK_ACTIVE(ext_act), .HOLD_EXEC(hold));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : xs

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Notes the answer first, so the monitor never finds an empty queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] want);
    int k;
    exp_q.push_back(want);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers counts against the run
    if (pready !== 1'b1)
      n_mismatch++;
  endtask : apb

  task automatic boot(input logic [2:0] m, input logic ts, input logic me);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    cfg_mode <= m;
    two_speed <= ts;
    mon_en <= me;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : boot

  always @(posedge ref_clk)
  begin
    if (pready === 1'b1)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    logic [31:0] d;
    logic tg;
    int n;
    scs_mode_t mt[4] = '{MODE_RC, MODE_RC_IO, MODE_INT_CLOCKOUT, MODE_INT_PIN_IO};
    logic [1:0] ex[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    boot(MODE_EXT_CLOCK, 1'b0, 1'b1);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h60);
    repeat (200) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      d = xs();
      d[7] = 1'b1;
      d[6:4] = i[2:0];
      apb(1, OSC_CTRL_OFFSET, d, 0);
      apb(0, OSC_CTRL_OFFSET, 0, {26'h0, d[6:4], 3'h2, d[0]});
    end
    apb(0, 12'h008, 0, 33'h100000000);
    apb(1, OSC_CTRL_OFFSET, 32'h60, 0);
    run <= 1'b1;
    repeat (100) @(posedge ref_clk);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h6c);
    check({ext_act, hold, in_oe_n, out_oe_n, out_o}, 33'h15);
    apb(1, OSC_CTRL_OFFSET, 32'h61, 0);
    repeat (100) @(posedge ref_clk);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h65);
    check(ext_act, 0);
    apb(1, OSC_CTRL_OFFSET, 32'h60, 0);
    repeat (100) @(posedge ref_clk);
    check(ext_act, 1);
    run <= 1'b0;
    repeat (10000) @(posedge ref_clk);
    check(ext_act, 0);
    apb(0, FAIL_STAT_OFFSET, 0, 33'h1);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h64);
    apb(1, FAIL_STAT_OFFSET, 32'h1, 0);
    apb(0, FAIL_STAT_OFFSET, 0, 33'h0);
    // Crystal start-up: period 6 cycles, so 1024 edges take about 6150 cycles
    run <= 1'b1;
    boot(MODE_LOW_POWER_XTAL, 1'b1, 1'b0);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h60);
    boot(MODE_LOW_POWER_XTAL, 1'b0, 1'b1);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h60);
    boot(MODE_LOW_POWER_XTAL, 1'b0, 1'b0);
    apb(0, OSC_CTRL_OFFSET, 0, 33'h68);
    repeat (5800) @(posedge ref_clk);
    check(hold, 1);
    repeat (800) @(posedge ref_clk);
    check({hold, ext_act}, 1);
    // Wake restarts the count, so execution is held again
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(hold, 1);
    for (int i = 0; i < 4; i++)
    begin
      boot(mt[i], 1'b0, 1'b0);
      repeat (300) @(posedge ref_clk);
      d[0] = out_o;
      tg = 1'b0;
      repeat (400)
      begin
        @(posedge ref_clk);
        tg = tg | (out_o !== d[0]);
      end
      check({in_oe_n, tg}, ex[i]);
    end
    // Still in internal pin I/O mode: both pins as general I/O
    d = xs();
    gpio_dout <= d[1:0];
    repeat (6) @(posedge ref_clk);
    check(gpio_din, d[1:0]);
    gpio_drive <= 2'h0;
    repeat (6) @(posedge ref_clk);
    check({in_oe_n, out_oe_n, gpio_din[1]}, 33'h7);
    // Internal rate: code 7 is every fast tick, code 1 one in 64
    apb(1, OSC_CTRL_OFFSET, 32'h70, 0);
    repeat (20) @(posedge ref_clk);
    n = 0;
    repeat (1200)
    begin
      @(posedge ref_clk);
      n += sys_en;
    end
    check(n, 1200 / FAST_DIV_CYCLES);
    apb(1, OSC_CTRL_OFFSET, 32'h10, 0);
    repeat (20) @(posedge ref_clk);
    n = 0;
    repeat (128 * FAST_DIV_CYCLES)
    begin
      @(posedge ref_clk);
      n += sys_en;
    end
    check(n, 2);
    stop_test();
  end
endmodule : scs_clock_selector_tb_top
